/* pwm_compare.sv */
// Purpose: Two dedicated outputs from plain bits, modulators or counter compares
// Assumes: Counts and STOP_MODE come from logic on REF_CLK; zero-wait AHB-Lite
// Notes: Frequencies above half the clock rate are clamped to half the clock rate
`timescale 1ns/1ps
`include "pwm_compare_params.svh"

module pwm_compare
  import pwm_compare_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [31:0] CLK_HZ = `REF_CLK_HZ
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [31:0] COUNT_ONE,
  input wire logic [31:0] COUNT_TWO,
  input wire logic STOP_MODE,
  output logic FIRST_DEDICATED_OUTPUT,
  output logic SECOND_DEDICATED_OUTPUT
);

  localparam logic [31:0] FULL = `DUTY_FULL_SCALE;
  localparam logic [31:0] HALF = {1'b0, CLK_HZ[31:1]};

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] clamp_duty(input logic [31:0] d);
    return (d > FULL) ? FULL : d;
  endfunction

  function automatic logic [31:0] clamp_step(input logic [31:0] f);
    return (f > HALF) ? HALF : f;
  endfunction

  // High while phase/CLK_HZ is below duty/FULL; cross-multiplied to avoid a divider
  function automatic logic pwm_high(input logic [31:0] phase, input logic [31:0] duty);
    logic [63:0] lhs;
    logic [63:0] rhs;
    lhs = {32'h0000_0000, phase} * {32'h0000_0000, FULL};
    rhs = {32'h0000_0000, clamp_duty(duty)} * {32'h0000_0000, CLK_HZ};
    return lhs < rhs;
  endfunction

  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  logic wr_pend_reg, wr_pend_next;
  logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [`CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
  logic [31:0] preset_reg [2];
  logic [31:0] preset_next [2];
  logic [31:0] duty_reg [2];
  logic [31:0] duty_next [2];
  logic [31:0] freq_reg [2];
  logic [31:0] freq_next [2];
  logic [31:0] sduty_reg [2];
  logic [31:0] sduty_next [2];
  logic [31:0] sfreq_reg [2];
  logic [31:0] sfreq_next [2];

  // ----------------------------------------
  // Channel state
  // ----------------------------------------
  logic run_reg [2];
  logic run_next [2];
  logic [31:0] phase_reg [2];
  logic [31:0] phase_next [2];
  logic [31:0] act_duty_reg [2];
  logic [31:0] act_duty_next [2];
  logic [31:0] act_freq_reg [2];
  logic [31:0] act_freq_next [2];
  logic pwm_lvl_reg [2];
  logic pwm_lvl_next [2];
  logic out_reg [2];
  logic out_next [2];
  logic hit [2];
  logic [31:0] count [2];
  logic [31:0] status;
  logic addr_phase;

  assign count[0] = COUNT_ONE;
  assign count[1] = COUNT_TWO;
  assign addr_phase = HSEL && HTRANS[1] && HREADY;

  // ----------------------------------------
  // Compare hits
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hit[i] = (preset_reg[i] != 32'h0000_0000) && (count[i] >= preset_reg[i]);
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[`STAT_OUT_LSB] = out_reg[0];
    status[`STAT_OUT_LSB+1] = out_reg[1];
    status[`STAT_RUN_LSB] = run_reg[0];
    status[`STAT_RUN_LSB+1] = run_reg[1];
    status[`STAT_HIT_LSB] = hit[0];
    status[`STAT_HIT_LSB+1] = hit[1];
  end

  // ----------------------------------------
  // Bus next state
  // ----------------------------------------
  always_comb begin
    wr_pend_next = addr_phase && HWRITE;
    wr_addr_next = HADDR;
    ctrl_next = ctrl_reg;
    preset_next = preset_reg;
    duty_next = duty_reg;
    freq_next = freq_reg;
    sduty_next = sduty_reg;
    sfreq_next = sfreq_reg;
    // Writes land in the data phase; unmapped addresses are ignored
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `ADDR_CONTROL: ctrl_next = HWDATA[`CTRL_WIDTH-1:0];
        `ADDR_PRESET_ONE: preset_next[0] = HWDATA;
        `ADDR_PRESET_TWO: preset_next[1] = HWDATA;
        `ADDR_DUTY_ONE: duty_next[0] = HWDATA;
        `ADDR_FREQ_ONE: freq_next[0] = HWDATA;
        `ADDR_DUTY_TWO: duty_next[1] = HWDATA;
        `ADDR_FREQ_TWO: freq_next[1] = HWDATA;
        `ADDR_STOP_DUTY_ONE: sduty_next[0] = HWDATA;
        `ADDR_STOP_FREQ_ONE: sfreq_next[0] = HWDATA;
        `ADDR_STOP_DUTY_TWO: sduty_next[1] = HWDATA;
        `ADDR_STOP_FREQ_TWO: sfreq_next[1] = HWDATA;
        default: ctrl_next = ctrl_reg;
      endcase
    end
    // Read data is captured in the address phase so it stands in the data phase
    rdata_next = rdata_reg;
    if (addr_phase && !HWRITE) begin
      unique case (HADDR)
        `ADDR_CONTROL: rdata_next = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_next};
        `ADDR_PRESET_ONE: rdata_next = preset_next[0];
        `ADDR_PRESET_TWO: rdata_next = preset_next[1];
        `ADDR_DUTY_ONE: rdata_next = duty_next[0];
        `ADDR_FREQ_ONE: rdata_next = freq_next[0];
        `ADDR_DUTY_TWO: rdata_next = duty_next[1];
        `ADDR_FREQ_TWO: rdata_next = freq_next[1];
        `ADDR_COUNT_ONE: rdata_next = COUNT_ONE;
        `ADDR_COUNT_TWO: rdata_next = COUNT_TWO;
        `ADDR_STOP_DUTY_ONE: rdata_next = sduty_next[0];
        `ADDR_STOP_FREQ_ONE: rdata_next = sfreq_next[0];
        `ADDR_STOP_DUTY_TWO: rdata_next = sduty_next[1];
        `ADDR_STOP_FREQ_TWO: rdata_next = sfreq_next[1];
        `ADDR_STATUS: rdata_next = status;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= `CTRL_RESET;
      for (int i = 0; i < 2; i++) begin
        preset_reg[i] <= `VALUE_RESET;
        duty_reg[i] <= `VALUE_RESET;
        freq_reg[i] <= `VALUE_RESET;
        sduty_reg[i] <= `VALUE_RESET;
        sfreq_reg[i] <= `VALUE_RESET;
      end
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      preset_reg <= preset_next;
      duty_reg <= duty_next;
      freq_reg <= freq_next;
      sduty_reg <= sduty_next;
      sfreq_reg <= sfreq_next;
    end
  end

  assign HRDATA = rdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ----------------------------------------
  // Modulator channels and output select
  // ----------------------------------------
  always_comb begin
    logic [32:0] sum;
    logic [31:0] tgt_d;
    logic [31:0] tgt_f;
    logic en;
    logic hold;
    out_mode_type mode;
    sum = 33'h0_0000_0000;
    tgt_d = 32'h0000_0000;
    tgt_f = 32'h0000_0000;
    en = 1'b0;
    hold = 1'b0;
    mode = MODE_PLAIN;
    for (int i = 0; i < 2; i++) begin
      en = ctrl_reg[`CTRL_PWM_EN_LSB+i];
      // stop mode picks hold or stop values
      hold = STOP_MODE && ctrl_reg[`CTRL_STOP_HOLD_LSB+i];
      tgt_d = STOP_MODE ? sduty_reg[i] : duty_reg[i];
      tgt_f = STOP_MODE ? sfreq_reg[i] : freq_reg[i];
      run_next[i] = run_reg[i];
      phase_next[i] = phase_reg[i];
      act_duty_next[i] = act_duty_reg[i];
      act_freq_next[i] = act_freq_reg[i];
      sum = {1'b0, phase_reg[i]} + {1'b0, clamp_step(act_freq_reg[i])};
      if (hold) begin
        run_next[i] = run_reg[i];
      end else if (!en || (STOP_MODE && (tgt_d == 32'h0000_0000 || tgt_f == 32'h0000_0000))) begin
        run_next[i] = 1'b0;
        phase_next[i] = 32'h0000_0000;
      end else if (!run_reg[i]) begin
        // start only once both values are non-zero
        run_next[i] = (tgt_d != 32'h0000_0000) && (tgt_f != 32'h0000_0000);
        phase_next[i] = 32'h0000_0000;
        act_duty_next[i] = tgt_d;
        act_freq_next[i] = tgt_f;
      end else if (sum >= {1'b0, CLK_HZ}) begin
        phase_next[i] = 32'(sum - {1'b0, CLK_HZ});
        // new values taken at period start
        act_duty_next[i] = tgt_d;
        act_freq_next[i] = tgt_f;
        run_next[i] = (tgt_d != 32'h0000_0000) && (tgt_f != 32'h0000_0000);
      end else begin
        phase_next[i] = sum[31:0];
      end
      // duty ratio with clamp to full scale
      pwm_lvl_next[i] = hold ? pwm_lvl_reg[i]
                             : run_next[i] && pwm_high(phase_next[i], act_duty_next[i]);
      mode = out_mode_type'(ctrl_reg[`CTRL_MODE_ONE_LSB+2*i +: 2]);
      unique case (mode)
        MODE_PLAIN: out_next[i] = ctrl_reg[`CTRL_OUT_BIT_LSB+i];
        MODE_PWM: out_next[i] = pwm_lvl_next[i];
        MODE_COMPARE: out_next[i] = hit[i];
        default: out_next[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 2; i++) begin
        run_reg[i] <= 1'b0;
        phase_reg[i] <= 32'h0000_0000;
        act_duty_reg[i] <= 32'h0000_0000;
        act_freq_reg[i] <= 32'h0000_0000;
        pwm_lvl_reg[i] <= 1'b0;
        out_reg[i] <= 1'b0;
      end
    end else begin
      run_reg <= run_next;
      phase_reg <= phase_next;
      act_duty_reg <= act_duty_next;
      act_freq_reg <= act_freq_next;
      pwm_lvl_reg <= pwm_lvl_next;
      out_reg <= out_next;
    end
  end

  assign FIRST_DEDICATED_OUTPUT = out_reg[0];
  assign SECOND_DEDICATED_OUTPUT = out_reg[1];

endmodule // pwm_compare

/* pwm_compare_monitor.sv */
// Purpose: Port checks for pwm_compare
// Assumes: Zero-wait bus; control word shadowed from bus writes
// Notes: Modulator duty and compare timing are judged by the bench
`timescale 1ns/1ps
`include "pwm_compare_params.svh"
module pwm_compare_monitor
  import pwm_compare_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic STOP_MODE,
  input wire logic FIRST_DEDICATED_OUTPUT,
  input wire logic SECOND_DEDICATED_OUTPUT
);
  // ----
  // Control shadow
  // ----
  logic pend_reg, pend_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [9:0] ctrl_reg, ctrl_next;
  logic rd_ctrl;
  out_mode_type m1, m2;
  assign m1 = out_mode_type'(ctrl_reg[1:0]);
  assign m2 = out_mode_type'(ctrl_reg[3:2]);
  assign rd_ctrl = HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR == `ADDR_CONTROL;
  always_comb begin
    pend_next = HSEL && HTRANS[1] && HREADY && HWRITE;
    addr_next = HADDR;
    ctrl_next = ctrl_reg;
    if (pend_reg && addr_reg == `ADDR_CONTROL) ctrl_next = HWDATA[9:0];
  end
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pend_reg <= 1'b0;
      addr_reg <= '0;
      ctrl_reg <= `CTRL_RESET;
    end else begin
      pend_reg <= pend_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  chk_plain_one: assert property ($past(m1) == MODE_PLAIN
    |-> FIRST_DEDICATED_OUTPUT == $past(ctrl_reg[8])) else $error("plain one wrong");
  chk_plain_two: assert property ($past(m2) == MODE_PLAIN
    |-> SECOND_DEDICATED_OUTPUT == $past(ctrl_reg[9])) else $error("plain two wrong");
  chk_unused_low: assert property ($past(m1) == MODE_UNUSED
    |-> !FIRST_DEDICATED_OUTPUT) else $error("unused mode drives high");
  chk_off_one: assert property ($past(m1) == MODE_PWM && !$past(ctrl_reg[4])
    && !$past(STOP_MODE) |-> !FIRST_DEDICATED_OUTPUT) else $error("disabled one high");
  chk_off_two: assert property ($past(m2) == MODE_PWM && !$past(ctrl_reg[5])
    && !$past(STOP_MODE) |-> !SECOND_DEDICATED_OUTPUT) else $error("disabled two high");
  chk_ctrl_read: assert property (rd_ctrl
    |=> HRDATA == {22'h000000, ctrl_reg}) else $error("control read wrong");
  chk_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or error");
  chk_reset_low: assert property ($past(SRST) |-> !FIRST_DEDICATED_OUTPUT
    && !SECOND_DEDICATED_OUTPUT && HRDATA == 32'h0) else $error("reset state wrong");
  cover property (m1 == MODE_PWM && FIRST_DEDICATED_OUTPUT);
  cover property (STOP_MODE && FIRST_DEDICATED_OUTPUT);
  cover property (m2 == MODE_COMPARE && SECOND_DEDICATED_OUTPUT);
endmodule // pwm_compare_monitor

bind pwm_compare pwm_compare_monitor #(.ADDR_W(ADDR_W)) mon_u (
  .REF_CLK(REF_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .STOP_MODE(STOP_MODE),
  .FIRST_DEDICATED_OUTPUT(FIRST_DEDICATED_OUTPUT),
  .SECOND_DEDICATED_OUTPUT(SECOND_DEDICATED_OUTPUT));

/* pwm_compare_params.svh */
// Purpose: Constants for the dual output modulator / compare block
// Assumes: AHB-Lite register access, 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses; count index of each 32-bit pair times four
`ifndef PWM_COMPARE_PARAMS_SVH
`define PWM_COMPARE_PARAMS_SVH

// ----------------------------------------
// Timing and scale
// ----------------------------------------
`define REF_CLK_HZ 32'h0BEB_C200
`define DUTY_FULL_SCALE 32'h0000_7D00

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define IDX_PRESET_ONE 3
`define IDX_PRESET_TWO 5
`define IDX_DUTY_ONE 7
`define IDX_FREQ_ONE 9
`define IDX_DUTY_TWO 11
`define IDX_FREQ_TWO 13
`define ADDR_CONTROL 12'h000
`define ADDR_PRESET_ONE 12'h00C
`define ADDR_PRESET_TWO 12'h014
`define ADDR_DUTY_ONE 12'h01C
`define ADDR_FREQ_ONE 12'h024
`define ADDR_DUTY_TWO 12'h02C
`define ADDR_FREQ_TWO 12'h034
`define ADDR_COUNT_ONE 12'h040
`define ADDR_COUNT_TWO 12'h044
`define ADDR_STOP_DUTY_ONE 12'h048
`define ADDR_STOP_FREQ_ONE 12'h04C
`define ADDR_STOP_DUTY_TWO 12'h050
`define ADDR_STOP_FREQ_TWO 12'h054
`define ADDR_STATUS 12'h058

// ----------------------------------------
// Control and status fields, reset values
// ----------------------------------------
`define CTRL_MODE_ONE_LSB 0
`define CTRL_MODE_TWO_LSB 2
`define CTRL_PWM_EN_LSB 4
`define CTRL_STOP_HOLD_LSB 6
`define CTRL_OUT_BIT_LSB 8
`define CTRL_WIDTH 10
`define CTRL_RESET 10'h000
`define STAT_OUT_LSB 0
`define STAT_RUN_LSB 2
`define STAT_HIT_LSB 4
`define VALUE_RESET 32'h0000_0000

`endif

/* pwm_compare_pkg.sv */
// Purpose: Types shared by the dual output modulator / compare block
// Assumes: Constants come from pwm_compare_params.svh
// Notes: Mode code 2'b11 is unused and drives the output low
package pwm_compare_pkg;

  typedef enum logic [1:0] {
    MODE_PLAIN   = 2'b00,
    MODE_PWM     = 2'b01,
    MODE_COMPARE = 2'b10,
    MODE_UNUSED  = 2'b11
  } out_mode_type;

  typedef logic [31:0] word_type;

endpackage

/* pwm_compare_tb_top.sv */
// Purpose: Self-checking bench for pwm_compare
// Assumes: CLK_HZ of 1000, so 100 Hz is a 10-cycle period
// Notes: Duties chosen to land on whole phase steps, so counts are exact
`timescale 1ns/1ps
`include "pwm_compare_params.svh"
module pwm_compare_tb_top import pwm_compare_pkg::*;;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic stop = 1'b0;
  word_type hwdata = 32'h0, cnt_one = 32'h0, cnt_two = 32'h0, hrdata;
  logic hreadyout, hresp, out_one, out_two;
  int fail_count = 0;
  int total_checks = 0;
  int h1, h2;
  logic [11:0] rw_a [10] = '{`ADDR_PRESET_ONE, `ADDR_PRESET_TWO, `ADDR_DUTY_ONE,
    `ADDR_FREQ_ONE, `ADDR_DUTY_TWO, `ADDR_FREQ_TWO, `ADDR_STOP_DUTY_ONE,
    `ADDR_STOP_FREQ_ONE, `ADDR_STOP_DUTY_TWO, `ADDR_STOP_FREQ_TWO};
  logic [11:0] pw_a [12] = '{12'h000, `ADDR_DUTY_ONE, 12'h000, `ADDR_FREQ_ONE,
    `ADDR_DUTY_TWO, `ADDR_FREQ_TWO, `ADDR_DUTY_ONE, `ADDR_DUTY_ONE, `ADDR_DUTY_ONE,
    `ADDR_DUTY_ONE, 12'h000, 12'h000};
  word_type pw_d [12] = '{32'h005, 32'h3E80, 32'h035, 32'h64, 32'h1F40, 32'hFA,
    32'h7D00, 32'h9C40, 32'h0, 32'h3E80, 32'h015, 32'h035};
  int pw_e1 [12] = '{0, 0, 0, 50, 50, 50, 100, 100, 0, 50, 50, 50};
  int pw_e2 [12] = '{0, 0, 0, 0, 0, 25, 25, 25, 25, 25, 0, 25};

  always #2.5 ref_clk = ~ref_clk;

  pwm_compare #(.CLK_HZ(32'h0000_03E8)) dut_u (
    .REF_CLK(ref_clk), .SRST(srst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .COUNT_ONE(cnt_one),
    .COUNT_TWO(cnt_two), .STOP_MODE(stop), .FIRST_DEDICATED_OUTPUT(out_one),
    .SECOND_DEDICATED_OUTPUT(out_two));

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input word_type got, input word_type exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Address phase held until ready, then data phase until ready
  task automatic xfer(input logic [11:0] a, input logic w, input word_type d,
                      output word_type q);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input word_type d);
    word_type q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input word_type exp, input string what);
    word_type q;
    xfer(a, 1'b0, 32'h0, q);
    check(q, exp, what);
  endtask

  // Settle past one period wrap, then count high cycles over 100
  task automatic count_high;
    h1 = 0;
    h2 = 0;
    repeat (30) @(posedge ref_clk);
    repeat (100) begin
      @(posedge ref_clk);
      h1 += int'(out_one === 1'b1);
      h2 += int'(out_two === 1'b1);
    end
  endtask

  initial begin
    #100000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    foreach (rw_a[i]) begin
      rd(rw_a[i], 32'h0, "reset value");
      wr(rw_a[i], 32'h1000 + 32'(i));
      rd(rw_a[i], 32'h1000 + 32'(i), "read back");
    end
    cnt_one <= 32'h1234_5678;
    wr(`ADDR_COUNT_ONE, 32'h0);
    rd(`ADDR_COUNT_ONE, 32'h1234_5678, "count read only");
    wr(12'h05C, 32'hFFFF_FFFF);
    rd(12'h05C, 32'h0, "unmapped");
    // Idle counts and modulators so compare or modulator modes stay low here
    cnt_one <= 32'h0;
    for (int i = 2; i < 6; i++) wr(rw_a[i], 32'h0);
    foreach (pw_d[i]) begin
      wr(`ADDR_CONTROL, {22'h0, 1'b0, 1'b1, 8'(i * 15)});
      repeat (2) @(posedge ref_clk);
      check(out_one, (i % 4) == 0, "plain one");
      check(out_two, 1'b0, "plain two");
    end
    wr(`ADDR_CONTROL, 32'h20A);
    wr(`ADDR_PRESET_ONE, 32'h5);
    wr(`ADDR_PRESET_TWO, 32'h9);
    for (int c = 4; c < 7; c++) begin
      cnt_one <= 32'(c);
      cnt_two <= 32'(c + 4);
      repeat (2) @(posedge ref_clk);
      check(out_one, c >= 5, "compare one");
      check(out_two, c >= 5, "compare two");
    end
    wr(`ADDR_PRESET_ONE, 32'h0);
    repeat (2) @(posedge ref_clk);
    check(out_one, 1'b0, "preset zero");
    foreach (pw_a[i]) begin
      wr(pw_a[i], pw_d[i]);
      count_high();
      check(h1, pw_e1[i], "modulator one");
      check(h2, pw_e2[i], "modulator two");
    end
    wr(`ADDR_STOP_DUTY_ONE, 32'h7D00);
    wr(`ADDR_STOP_FREQ_ONE, 32'h64);
    wr(`ADDR_STOP_DUTY_TWO, 32'h3E80);
    wr(`ADDR_STOP_FREQ_TWO, 32'h0);
    stop <= 1'b1;
    count_high();
    check(h1, 100, "stop values one");
    check(h2, 0, "stop zero two");
    stop <= 1'b0;
    count_high();
    check(h2, 25, "resume two");
    wr(`ADDR_CONTROL, 32'h0F5);
    stop <= 1'b1;
    count_high();
    check(h1 % 100, 0, "hold one");
    check(h2 % 100, 0, "hold two");
    close_out();
  end
endmodule // pwm_compare_tb_top
